// *** core/cfg_loader_cfg.svh ***
// Constants shared by both ends of the parallel configuration link.
`ifndef CFG_LOADER_CFG_SVH
`define CFG_LOADER_CFG_SVH
`define CFG_CORE_MHZ       250
`define CFG_WORD_W         32
`define CFG_FIFO_DEPTH     32
`define CFG_POR_US         268
`define CFG_INIT_US        175
`define CFG_REQ_LOW_US     2
`define CFG_REQ_LOW_CYC    (`CFG_REQ_LOW_US * `CFG_CORE_MHZ)
`define CFG_HALF_CYC       4
`define CFG_DONE_FALLS     2
`define CFG_OPT_INIT_BIT   0
`define CFG_IMG_W          32
`endif

// *** core/cfg_loader_pkg.sv ***
// Types shared by both ends of the parallel configuration link.
package cfg_loader_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  ratio_t;
  typedef enum logic [1:0] {width_8, width_16, width_32} width_e;
  typedef enum {st_hold, st_por, st_load, st_done, st_init, st_user} dev_state_e;
  typedef enum {h_idle, h_req, h_wait_status, h_send, h_wait_done, h_finish} host_state_e;

  function automatic word_t mask_word(input width_e w, input word_t d);
    word_t m;
    m = d;
    if (w == width_8) begin
      m = {24'h000000, d[7:0]};
    end else if (w == width_16) begin
      m = {16'h0000, d[15:0]};
    end
    return m;
  endfunction
endpackage

// *** core/cfg_link_if.sv ***
// Pins between the configuration host and the configured device.
`timescale 1ns/1ps
interface cfg_link_if;
  logic        config_request_n;
  logic        config_clock;
  logic [31:0] data;
  logic        status_n;
  logic        load_complete;
  logic        init_done;
  logic        init_done_en;

  modport device (
    input  config_request_n,
    input  config_clock,
    input  data,
    output status_n,
    output load_complete,
    output init_done,
    output init_done_en
  );

  modport host (
    output config_request_n,
    output config_clock,
    output data,
    input  status_n,
    input  load_complete,
    input  init_done,
    input  init_done_en
  );
endinterface

// *** core/cfg_fifo.sv ***
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cfg_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign count_nxt   = count_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r    <= count_nxt;
      o_in_ready <= (count_nxt < (AW+1)'(DEPTH));
    end
  end
endmodule

// *** core/cfg_device_end.sv ***
// Configured device end of the parallel configuration link.
`timescale 1ns/1ps
`include "cfg_loader_cfg.svh"
module cfg_device_end #(
  parameter int unsigned POR_CYCLES  = `CFG_POR_US * `CFG_CORE_MHZ,
  parameter int unsigned INIT_CYCLES = `CFG_INIT_US * `CFG_CORE_MHZ
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset_n,
  cfg_link_if.device                     link,
  input  wire cfg_loader_pkg::width_e    i_width,
  input  wire cfg_loader_pkg::ratio_t    i_ratio,
  input  wire logic [`CFG_IMG_W-1:0]     i_image_words,
  output logic                           o_word_valid,
  output cfg_loader_pkg::word_t          o_word_data,
  output logic                           o_user_mode,
  output logic                           o_busy
);
  import cfg_loader_pkg::*;

  dev_state_e              state_r;
  dev_state_e              state_nxt;
  logic                    clk_s1_r;
  logic                    clk_s2_r;
  logic                    clk_s3_r;
  logic                    req_s1_r;
  logic                    req_s2_r;
  word_t                   data_s1_r;
  word_t                   data_s2_r;
  logic                    rise;
  logic                    fall;
  logic [31:0]             delay_cnt_r;
  logic                    delay_done;
  ratio_t                  ratio_m1;
  ratio_t                  rise_cnt_r;
  logic [`CFG_IMG_W-1:0]   word_cnt_r;
  logic                    latch;
  logic                    last_latch;
  logic [1:0]              fall_cnt_r;
  logic                    init_opt_r;
  logic                    status_n_r;
  logic                    load_complete_r;
  logic                    init_done_r;
  logic                    init_done_en_r;

  // Link pins are driven straight from registers.
  assign link.status_n      = status_n_r;
  assign link.load_complete = load_complete_r;
  assign link.init_done     = init_done_r;
  assign link.init_done_en  = init_done_en_r;

  // Pins from the host pass two flip-flops before use.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_s1_r  <= 1'b0;
      clk_s2_r  <= 1'b0;
      clk_s3_r  <= 1'b0;
      req_s1_r  <= 1'b1;
      req_s2_r  <= 1'b1;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end else begin
      clk_s1_r  <= link.config_clock;
      clk_s2_r  <= clk_s1_r;
      clk_s3_r  <= clk_s2_r;
      req_s1_r  <= link.config_request_n;
      req_s2_r  <= req_s1_r;
      data_s1_r <= link.data;
      data_s2_r <= data_s1_r;
    end
  end

  // A clock held low yields no edges, so loading simply waits.
  assign rise = clk_s2_r && !clk_s3_r;
  assign fall = !clk_s2_r && clk_s3_r;

  assign ratio_m1   = (i_ratio == '0) ? '0 : i_ratio - 1'b1;
  assign latch      = (state_r == st_load) && rise && (rise_cnt_r == '0);
  assign last_latch = latch && (word_cnt_r == i_image_words - 1'b1);

  assign delay_done =
    ((state_r == st_por) && (delay_cnt_r == 32'(POR_CYCLES - 1))) ||
    ((state_r == st_init) && (delay_cnt_r == 32'(INIT_CYCLES - 1)));

  // Next state of the configuration sequence.
  always_comb begin
    state_nxt = state_r;
    if (!req_s2_r) begin
      state_nxt = st_hold;
    end else begin
      unique case (state_r)
        st_hold: begin
          state_nxt = st_por;
        end
        st_por: begin
          if (delay_done) begin
            state_nxt = st_load;
          end
        end
        st_load: begin
          if (last_latch) begin
            state_nxt = st_done;
          end
        end
        st_done: begin
          if (fall && (fall_cnt_r == 2'(`CFG_DONE_FALLS - 1))) begin
            state_nxt = st_init;
          end
        end
        st_init: begin
          if (delay_done) begin
            state_nxt = st_user;
          end
        end
        st_user: begin
          state_nxt = st_user;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= st_por;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Delay counter for the power-on hold and the initialization time.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      delay_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      delay_cnt_r <= '0;
    end else if ((state_r == st_por) || (state_r == st_init)) begin
      delay_cnt_r <= delay_cnt_r + 1'b1;
    end
  end

  // Rising edges counted within one word period.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rise_cnt_r <= '0;
    end else if (state_r != st_load) begin
      rise_cnt_r <= '0;
    end else if (rise) begin
      rise_cnt_r <= (rise_cnt_r == ratio_m1) ? '0 : rise_cnt_r + 1'b1;
    end
  end

  // Words received so far.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_cnt_r <= '0;
    end else if (state_r != st_load) begin
      word_cnt_r <= '0;
    end else if (latch) begin
      word_cnt_r <= word_cnt_r + 1'b1;
    end
  end

  // Falling edges after load-complete has risen.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fall_cnt_r <= '0;
    end else if (state_r != st_done) begin
      fall_cnt_r <= '0;
    end else if (fall) begin
      fall_cnt_r <= fall_cnt_r + 1'b1;
    end
  end

  // Received words go to the user side, masked to the active lines.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_word_valid <= 1'b0;
      o_word_data  <= '0;
    end else begin
      o_word_valid <= latch;
      if (latch) begin
        o_word_data <= mask_word(i_width, data_s2_r);
      end
    end
  end

  // The init pin option is carried in the first word of the image.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_opt_r <= 1'b0;
    end else if ((state_r == st_hold) || (state_r == st_por)) begin
      init_opt_r <= 1'b0;
    end else if (latch && (word_cnt_r == '0)) begin
      init_opt_r <= data_s2_r[`CFG_OPT_INIT_BIT];
    end
  end

  // Status pin: low during request hold and power-on delay.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_n_r <= 1'b0;
    end else begin
      status_n_r <= !((state_nxt == st_hold) || (state_nxt == st_por));
    end
  end

  // Load-complete: low until the whole image has arrived.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_complete_r <= 1'b0;
    end else begin
      load_complete_r <= (state_nxt == st_done) || (state_nxt == st_init) ||
                         (state_nxt == st_user);
    end
  end

  // Init pin: driven low once enabled, released in user mode.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_done_r    <= 1'b0;
      init_done_en_r <= 1'b0;
    end else begin
      init_done_r    <= (state_nxt == st_user);
      init_done_en_r <= init_opt_r;
    end
  end

  // User-side status.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_user_mode <= 1'b0;
      o_busy      <= 1'b1;
    end else begin
      o_user_mode <= (state_nxt == st_user);
      o_busy      <= (state_nxt != st_user);
    end
  end
endmodule

// *** core/cfg_host_end.sv ***
// Host end of the parallel configuration link.
`timescale 1ns/1ps
`include "cfg_loader_cfg.svh"
module cfg_host_end (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset_n,
  cfg_link_if.host                       link,
  input  wire logic                      i_start,
  input  wire cfg_loader_pkg::width_e    i_width,
  input  wire cfg_loader_pkg::ratio_t    i_ratio,
  input  wire logic [`CFG_IMG_W-1:0]     i_image_words,
  input  wire logic                      i_wr_valid,
  input  wire cfg_loader_pkg::word_t     i_wr_data,
  output logic                           o_wr_ready,
  output logic                           o_busy,
  output logic                           o_done
);
  import cfg_loader_pkg::*;

  host_state_e             state_r;
  logic                    stat_s1_r;
  logic                    stat_s2_r;
  logic                    done_s1_r;
  logic                    done_s2_r;
  logic                    req_n_r;
  logic                    clk_r;
  word_t                   data_r;
  logic [31:0]             cnt_r;
  logic [2:0]              half_r;
  ratio_t                  per_r;
  ratio_t                  ratio_m1;
  logic                    have_word_r;
  logic [`CFG_IMG_W-1:0]   sent_r;
  logic [1:0]              falls_r;
  logic                    fifo_valid;
  word_t                   fifo_data;
  logic                    pop;
  logic                    half_end;

  assign link.config_request_n = req_n_r;
  assign link.config_clock     = clk_r;
  assign link.data             = data_r;

  assign ratio_m1 = (i_ratio == '0) ? '0 : i_ratio - 1'b1;
  assign half_end = (half_r == 3'(`CFG_HALF_CYC - 1));
  assign pop      = (state_r == h_send) && !clk_r && !have_word_r && fifo_valid;

  cfg_fifo #(
    .WIDTH (`CFG_WORD_W),
    .DEPTH (`CFG_FIFO_DEPTH)
  ) cfg_fifo_i (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_wr_valid),
    .i_in_data   (i_wr_data),
    .o_in_ready  (o_wr_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (pop)
  );

  // Device pins pass two flip-flops before use.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_s1_r <= 1'b0;
      stat_s2_r <= 1'b0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      stat_s1_r <= link.status_n;
      stat_s2_r <= stat_s1_r;
      done_s1_r <= link.load_complete;
      done_s2_r <= done_s1_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r     <= h_idle;
      req_n_r     <= 1'b1;
      clk_r       <= 1'b0;
      data_r      <= '0;
      cnt_r       <= '0;
      half_r      <= '0;
      per_r       <= '0;
      have_word_r <= 1'b0;
      sent_r      <= '0;
      falls_r     <= '0;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_r)
        h_idle: begin
          if (i_start) begin
            state_r <= h_req;
            req_n_r <= 1'b0;
            cnt_r   <= '0;
            o_busy  <= 1'b1;
          end
        end
        h_req: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == 32'(`CFG_REQ_LOW_CYC - 1)) begin
            req_n_r <= 1'b1;
            state_r <= h_wait_status;
          end
        end
        h_wait_status: begin
          sent_r      <= '0;
          per_r       <= '0;
          half_r      <= '0;
          have_word_r <= 1'b0;
          if (stat_s2_r) begin
            state_r <= h_send;
          end
        end
        h_send: begin
          if (!clk_r) begin
            if (!have_word_r) begin
              if (fifo_valid) begin
                data_r      <= mask_word(i_width, fifo_data);
                have_word_r <= 1'b1;
                half_r      <= '0;
              end
            end else if (half_end) begin
              clk_r  <= 1'b1;
              half_r <= '0;
            end else begin
              half_r <= half_r + 1'b1;
            end
          end else if (half_end) begin
            clk_r  <= 1'b0;
            half_r <= '0;
            if (per_r == ratio_m1) begin
              per_r       <= '0;
              have_word_r <= 1'b0;
              sent_r      <= sent_r + 1'b1;
              if (sent_r == i_image_words - 1'b1) begin
                state_r <= h_wait_done;
                falls_r <= '0;
              end
            end else begin
              per_r <= per_r + 1'b1;
            end
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        h_wait_done: begin
          if (half_end) begin
            half_r <= '0;
            clk_r  <= !clk_r;
            if (clk_r && done_s2_r) begin
              falls_r <= falls_r + 1'b1;
              if (falls_r == 2'(`CFG_DONE_FALLS - 1)) begin
                state_r <= h_finish;
              end
            end
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        h_finish: begin
          clk_r   <= 1'b0;
          o_done  <= 1'b1;
          o_busy  <= 1'b0;
          state_r <= h_idle;
        end
      endcase
    end
  end
endmodule

// *** tb/cfg_link_asserts.sv ***
// Concurrent checks on the pins between the configuration host and device.
`timescale 1ns/1ps
`include "cfg_loader_cfg.svh"
module cfg_link_asserts #(
  parameter int unsigned POR_CYCLES = 50
) (
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic        config_request_n,
  input wire logic        config_clock,
  input wire logic [31:0] data,
  input wire logic        status_n,
  input wire logic        load_complete,
  input wire logic        init_done,
  input wire logic        init_done_en
);
  localparam int REQ_LOW_CYC = `CFG_REQ_LOW_CYC;
  logic [31:0] por_cnt_r;
  logic [31:0] req_cnt_r;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Counts consecutive cycles of status low.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      por_cnt_r <= 32'h0;
    end else if (!status_n) begin
      por_cnt_r <= por_cnt_r + 32'h1;
    end else begin
      por_cnt_r <= 32'h0;
    end
  end

  // Counts consecutive cycles of request low.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_cnt_r <= 32'h0;
    end else if (!config_request_n) begin
      req_cnt_r <= req_cnt_r + 32'h1;
    end else begin
      req_cnt_r <= 32'h0;
    end
  end

  a_status_por_hold: assert property ($rose(status_n) |-> por_cnt_r >= POR_CYCLES - 1)
    else $error("status released before power-on delay");
  a_done_low_por: assert property (!status_n |-> !load_complete)
    else $error("load complete high while status low");
  a_request_restarts: assert property ($fell(config_request_n) |-> ##[1:4] !status_n)
    else $error("request low did not pull status low");
  a_done_until_request: assert property ($fell(load_complete) |-> !$past(config_request_n, 2))
    else $error("load complete dropped without request");
  a_user_pins_high: assert property (init_done_en && init_done && config_request_n
    && $past(config_request_n, 4) |-> status_n && load_complete)
    else $error("user mode pins not high");
  a_init_low_loading: assert property (init_done_en && !load_complete |-> !init_done)
    else $error("init pin high before loading finished");
  a_request_width: assert property ($rose(config_request_n) |-> req_cnt_r >= REQ_LOW_CYC)
    else $error("request low pulse too short");
  a_data_before_rise: assert property (config_clock |-> $stable(data))
    else $error("data changed while link clock high");
  a_clock_high_time: assert property ($rose(config_clock) |-> config_clock[*4] ##1 !config_clock)
    else $error("link clock high phase wrong");

  c_request: cover property ($fell(config_request_n));
  c_loaded: cover property ($rose(load_complete));
  c_init: cover property (init_done_en && $rose(init_done));
endmodule

// *** tb/parallel_config_loader_multi_clock_test.sv ***
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
module parallel_config_loader_multi_clock_test;
  import cfg_loader_pkg::*;
  logic        i_core_clk;
  logic        i_reset_n;
  logic        start;
  width_e      width;
  ratio_t      ratio;
  logic [31:0] n_words;
  logic        wr_valid;
  word_t       wr_data;
  logic        wr_ready;
  logic        host_busy;
  logic        host_done;
  logic        word_valid;
  word_t       word_data;
  logic        user_mode;
  logic        dev_busy;
  int          n_mismatch;
  int          check_count;
  int          cycles;
  word_t       exp_q[$];

  cfg_link_if cfg_link_if_i();
  wire init_pin = cfg_link_if_i.init_done_en ? cfg_link_if_i.init_done : 1'b1;

  cfg_device_end #(.POR_CYCLES(50), .INIT_CYCLES(40)) cfg_device_end_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(cfg_link_if_i.device),
    .i_width(width), .i_ratio(ratio), .i_image_words(n_words), .o_word_valid(word_valid),
    .o_word_data(word_data), .o_user_mode(user_mode), .o_busy(dev_busy));
  cfg_host_end cfg_host_end_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(cfg_link_if_i.host),
    .i_start(start), .i_width(width), .i_ratio(ratio), .i_image_words(n_words),
    .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready), .o_busy(host_busy),
    .o_done(host_done));
  cfg_link_asserts #(.POR_CYCLES(50)) cfg_link_asserts_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .config_request_n(cfg_link_if_i.config_request_n),
    .config_clock(cfg_link_if_i.config_clock), .data(cfg_link_if_i.data),
    .status_n(cfg_link_if_i.status_n), .load_complete(cfg_link_if_i.load_complete),
    .init_done(cfg_link_if_i.init_done), .init_done_en(cfg_link_if_i.init_done_en));

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Every latched word is compared with the next expected one.
  always @(posedge i_core_clk) begin
    if (word_valid === 1'b1) begin
      check_eq(word_data, exp_q.size() != 0 ? exp_q.pop_front() : ~word_data);
    end
  end

  function automatic word_t masked(input width_e w, input word_t d);
    return w == width_8 ? {24'h000000, d[7:0]} : w == width_16 ? {16'h0000, d[15:0]} : d;
  endfunction

  function automatic word_t word_of(input int k, input word_t salt);
    return word_t'(32'h9E37_79B9 * (k + 1)) ^ salt;
  endfunction

  task automatic push(input word_t w);
    @(negedge i_core_clk);
    wr_valid = 1'b1;
    wr_data = w;
    @(posedge i_core_clk);
    while (wr_ready !== 1'b1) @(posedge i_core_clk);
    exp_q.push_back(masked(width, w));
  endtask

  task automatic push_stop();
    @(negedge i_core_clk);
    wr_valid = 1'b0;
  endtask

  task automatic run_cfg(input width_e w, input ratio_t r, input int n, input int pre,
                         input word_t salt);
    int k;
    @(negedge i_core_clk);
    width = w;
    ratio = r;
    n_words = n;
    for (k = 0; k < pre; k++) push(word_of(k, salt));
    push_stop();
    if (pre == 32) begin
      @(negedge i_core_clk);
      check_eq(wr_ready, 1'b0);
      wr_valid = 1'b1;
      wr_data = 32'hDEAD_BEEF;
      repeat (3) @(negedge i_core_clk);
      wr_valid = 1'b0;
    end
    @(negedge i_core_clk);
    start = 1'b1;
    @(negedge i_core_clk);
    start = 1'b0;
    repeat (20) @(negedge i_core_clk);
    check_eq({host_busy, user_mode, cfg_link_if_i.config_request_n, cfg_link_if_i.status_n},
             4'h8);
    if (pre < n) begin
      repeat (1000) @(negedge i_core_clk);
      check_eq({cfg_link_if_i.config_clock, cfg_link_if_i.load_complete}, 2'h0);
      for (k = pre; k < n; k++) push(word_of(k, salt));
      push_stop();
    end
    wait (cfg_link_if_i.load_complete === 1'b1);
    @(negedge i_core_clk);
    check_eq({init_pin, user_mode}, 32'({~word_of(0, salt) & 32'h1, 1'b0}));
    wait (host_done === 1'b1);
    wait (user_mode === 1'b1);
    @(negedge i_core_clk);
    check_eq(exp_q.size(), 32'h0);
    check_eq({cfg_link_if_i.status_n, cfg_link_if_i.load_complete,
              cfg_link_if_i.config_request_n, init_pin, dev_busy, host_busy, wr_ready,
              cfg_link_if_i.config_clock}, 8'hF2);
  endtask

  initial begin
    i_reset_n = 1'b0;
    start = 1'b0;
    width = width_32;
    ratio = 4'h1;
    n_words = 32'h1;
    wr_valid = 1'b0;
    wr_data = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(negedge i_core_clk);
    check_eq({cfg_link_if_i.status_n, cfg_link_if_i.load_complete, user_mode}, 3'h0);
    i_reset_n = 1'b1;
    run_cfg(width_32, 4'h1, 4, 2, 32'h0);
    run_cfg(width_8, 4'h3, 3, 3, 32'h1);
    run_cfg(width_16, 4'h2, 32, 32, 32'h0);
    finish_test();
  end
endmodule
